// ===== hw/tls_pkg.sv
package tls_pkg;

   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   localparam logic [7:0] REG_SOURCE = 8'h00;
   localparam logic [7:0] REG_DETECT = 8'h04;
   localparam logic [7:0] REG_LINES = 8'h08;
   localparam logic [7:0] REG_ARM_OUT = 8'h0c;
   localparam logic [7:0] REG_TRIG_OUT = 8'h10;
   localparam logic [7:0] REG_DELAY = 8'h14;
   localparam logic [7:0] REG_POINTS = 8'h18;
   localparam logic [7:0] REG_PULSE = 8'h1c;
   localparam logic [7:0] REG_CMD = 8'h20;
   localparam logic [7:0] REG_STATUS = 8'h24;

   localparam int SRC_BUS_BIT = 0;
   localparam int DET_NONE_BIT = 3;
   localparam int ARM_NONE_BIT = 2;
   localparam int TRIG_NONE_BIT = 3;
   localparam int LINE_IN_LSB = 0;
   localparam int LINE_OUT_LSB = 4;
   localparam int CMD_START_BIT = 0;
   localparam int CMD_ABORT_BIT = 1;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_STATE_LSB = 4;
   localparam int STAT_POINT_LSB = 16;

   localparam logic RST_SRC_SEL = 1'b0;
   localparam logic [2:0] RST_DETECT = 3'h0;
   localparam logic [1:0] RST_ARM_OUT = 2'h0;
   localparam logic [2:0] RST_TRIG_OUT = 3'h0;
   localparam logic [1:0] RST_IN_LINE = 2'h0;
   localparam logic [1:0] RST_OUT_LINE = 2'h1;
   localparam logic [31:0] RST_DELAY = 32'h0;
   localparam logic [15:0] RST_POINTS = 16'h1;

   localparam int CLK_PERIOD_NS = 10;
   localparam int PULSE_TIME_NS = 1000;
   localparam int PULSE_CYCLES = (PULSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [15:0] RST_PULSE = 16'(PULSE_CYCLES);

   typedef enum logic [11:0] {
      S_IDLE = 12'h001,
      S_ENTER = 12'h002,
      S_WSRC = 12'h004,
      S_SRC = 12'h008,
      S_SOUT = 12'h010,
      S_WDLY = 12'h020,
      S_DLY = 12'h040,
      S_DOUT = 12'h080,
      S_WMEAS = 12'h100,
      S_MEAS = 12'h200,
      S_MOUT = 12'h400,
      S_EXIT = 12'h800
   } tls_state_e;

   // A list with names replaces the set; a lone none clears it; an empty list changes nothing.
   function automatic logic [2:0] tls_event_list(input logic [2:0] old_set,
                                                 input logic [2:0] names,
                                                 input logic none_flag);
      logic [2:0] result;
      result = old_set;
      if (names != 3'h0) begin
         result = names;
      end else if (none_flag) begin
         result = 3'h0;
      end
      return result;
   endfunction

endpackage

// ===== hw/tls_in_sync.sv
`timescale 1ns/1ps
module tls_in_sync #(
   parameter int LINES = 4
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [LINES-1:0] line_in,
   output logic [LINES-1:0] fall
);
   logic [LINES-1:0] stage1;
   logic [LINES-1:0] stage2;
   logic [LINES-1:0] stage3;
   logic [LINES-1:0] next_stage1;
   logic [LINES-1:0] next_stage2;
   logic [LINES-1:0] next_stage3;

   always_comb begin
      next_stage1 = line_in;
      next_stage2 = stage1;
      next_stage3 = stage2;
   end

   // Idle lines float high, so the reset value is all ones.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         stage1 <= '1;
         stage2 <= '1;
         stage3 <= '1;
      end else begin
         stage1 <= next_stage1;
         stage2 <= next_stage2;
         stage3 <= next_stage3;
      end
   end

   assign fall = stage3 & ~stage2;

endmodule // tls_in_sync

// ===== hw/tls_pulse_out.sv
`timescale 1ns/1ps
module tls_pulse_out #(
   parameter int LINES = 4,
   parameter int LEN_W = 16
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic fire,
   input wire logic [1:0] line_sel,
   input wire logic [LEN_W-1:0] length,
   output logic [LINES-1:0] line_out,
   output logic [LINES-1:0] line_oe_n,
   output logic busy
);
   logic [LEN_W-1:0] count;
   logic [LEN_W-1:0] next_count;
   logic [LINES-1:0] next_oe_n;
   logic next_busy;

   always_comb begin
      next_count = count;
      next_oe_n = line_oe_n;
      next_busy = busy;
      if (fire && !busy) begin
         next_count = (length == '0) ? LEN_W'(1) : length;
         next_oe_n = ~(LINES'(1) << line_sel);
         next_busy = 1'b1;
      end else if (busy) begin
         next_count = count - LEN_W'(1);
         if (count == LEN_W'(1)) begin
            next_oe_n = '1;
            next_busy = 1'b0;
         end
      end
   end

   // The line is pulled low for exactly length cycles (one cycle when length is zero), then released.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         count <= '0;
         line_oe_n <= '1;
         busy <= 1'b0;
         line_out <= '0;
      end else begin
         count <= next_count;
         line_oe_n <= next_oe_n;
         busy <= next_busy;
         line_out <= '0;
      end
   end

endmodule // tls_pulse_out

// ===== hw/tls_top.sv
`timescale 1ns/1ps
module tls_top #(
   parameter int LINES = 4,
   parameter int DLY_W = 32,
   parameter int PTS_W = 16
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [LINES-1:0] trig_line_in,
   output logic [LINES-1:0] trig_line_out,
   output logic [LINES-1:0] trig_line_oe_n,
   output logic src_apply,
   input wire logic src_done,
   output logic meas_start,
   input wire logic meas_done,
   output logic seq_busy
);
   logic src_sel;
   logic [2:0] det_en;
   logic [1:0] in_line;
   logic [1:0] out_line;
   logic [1:0] arm_out_en;
   logic [2:0] trig_out_en;
   logic [DLY_W-1:0] delay_val;
   logic [PTS_W-1:0] points;
   logic [15:0] pulse_len;
   logic next_src_sel;
   logic [2:0] next_det_en;
   logic [1:0] next_in_line;
   logic [1:0] next_out_line;
   logic [1:0] next_arm_out_en;
   logic [2:0] next_trig_out_en;
   logic [DLY_W-1:0] next_delay_val;
   logic [PTS_W-1:0] next_points;
   logic [15:0] next_pulse_len;
   logic [31:0] next_readdata;
   logic next_waitrequest;
   logic [2:0] arm_names;
   logic [2:0] arm_list;

   tls_pkg::tls_state_e state;
   tls_pkg::tls_state_e next_state;
   logic [DLY_W-1:0] dly_count;
   logic [DLY_W-1:0] next_dly_count;
   logic [PTS_W-1:0] pts_done;
   logic [PTS_W-1:0] next_pts_done;
   logic fire;
   logic next_fire;
   logic next_src_apply;
   logic next_meas_start;
   logic next_seq_busy;

   logic wr_take;
   logic rd_take;
   logic start_req;
   logic abort_req;
   logic [LINES-1:0] fall;
   logic trig_seen;
   logic out_busy;
   logic pulse_busy;
   logic last_point;

   assign wr_take = avs_write && !avs_waitrequest;
   assign rd_take = avs_read && avs_waitrequest;
   assign start_req = wr_take && (avs_address == tls_pkg::REG_CMD)
                      && avs_writedata[tls_pkg::CMD_START_BIT];
   assign abort_req = wr_take && (avs_address == tls_pkg::REG_CMD)
                      && avs_writedata[tls_pkg::CMD_ABORT_BIT];
   assign trig_seen = fall[in_line];
   assign out_busy = pulse_busy || fire;
   assign last_point = (pts_done + PTS_W'(1) >= points) || (points == '0);
   assign arm_names = {1'b0, avs_writedata[1:0]};
   assign arm_list = tls_pkg::tls_event_list({1'b0, arm_out_en}, arm_names,
                                             avs_writedata[tls_pkg::ARM_NONE_BIT]);

   // Detector is passed when not stalling, or when a pulse arrives on the input line.
   function automatic logic detector_pass(input logic bus_sel, input logic enabled,
                                          input logic seen);
      return !(bus_sel && enabled) || seen;
   endfunction

   tls_in_sync #(
      .LINES(LINES)
   ) u_in_sync (
      .mclk(mclk),
      .rst_n(rst_n),
      .line_in(trig_line_in),
      .fall(fall)
   );

   tls_pulse_out #(
      .LINES(LINES),
      .LEN_W(16)
   ) u_pulse_out (
      .mclk(mclk),
      .rst_n(rst_n),
      .fire(fire),
      .line_sel(out_line),
      .length(pulse_len),
      .line_out(trig_line_out),
      .line_oe_n(trig_line_oe_n),
      .busy(pulse_busy)
   );

   // Register file and bus answer; every access is answered in the cycle after it is seen.
   always_comb begin
      next_src_sel = src_sel;
      next_det_en = det_en;
      next_in_line = in_line;
      next_out_line = out_line;
      next_arm_out_en = arm_out_en;
      next_trig_out_en = trig_out_en;
      next_delay_val = delay_val;
      next_points = points;
      next_pulse_len = pulse_len;
      next_waitrequest = !((avs_read || avs_write) && avs_waitrequest);
      next_readdata = avs_readdata;
      if (wr_take) begin
         case (avs_address)
            tls_pkg::REG_SOURCE: begin
               next_src_sel = avs_writedata[tls_pkg::SRC_BUS_BIT];
            end
            tls_pkg::REG_DETECT: begin
               next_det_en = tls_pkg::tls_event_list(det_en, avs_writedata[2:0],
                  avs_writedata[tls_pkg::DET_NONE_BIT]);
            end
            tls_pkg::REG_LINES: begin
               next_in_line = avs_writedata[tls_pkg::LINE_IN_LSB +: 2];
               next_out_line = avs_writedata[tls_pkg::LINE_OUT_LSB +: 2];
            end
            tls_pkg::REG_ARM_OUT: begin
               next_arm_out_en = arm_list[1:0];
            end
            tls_pkg::REG_TRIG_OUT: begin
               next_trig_out_en = tls_pkg::tls_event_list(trig_out_en, avs_writedata[2:0],
                  avs_writedata[tls_pkg::TRIG_NONE_BIT]);
            end
            tls_pkg::REG_DELAY: begin
               next_delay_val = avs_writedata[DLY_W-1:0];
            end
            tls_pkg::REG_POINTS: begin
               next_points = avs_writedata[PTS_W-1:0];
            end
            tls_pkg::REG_PULSE: begin
               next_pulse_len = avs_writedata[15:0];
            end
            default: begin
            end
         endcase
      end
      if (rd_take) begin
         case (avs_address)
            tls_pkg::REG_SOURCE: next_readdata = 32'(src_sel);
            tls_pkg::REG_DETECT: next_readdata = 32'(det_en);
            tls_pkg::REG_LINES: begin
               next_readdata = 32'h0;
               next_readdata[tls_pkg::LINE_IN_LSB +: 2] = in_line;
               next_readdata[tls_pkg::LINE_OUT_LSB +: 2] = out_line;
            end
            tls_pkg::REG_ARM_OUT: next_readdata = 32'(arm_out_en);
            tls_pkg::REG_TRIG_OUT: next_readdata = 32'(trig_out_en);
            tls_pkg::REG_DELAY: next_readdata = 32'(delay_val);
            tls_pkg::REG_POINTS: next_readdata = 32'(points);
            tls_pkg::REG_PULSE: next_readdata = 32'(pulse_len);
            tls_pkg::REG_STATUS: begin
               next_readdata = 32'h0;
               next_readdata[tls_pkg::STAT_BUSY_BIT] = seq_busy;
               next_readdata[tls_pkg::STAT_STATE_LSB +: 12] = state;
               next_readdata[tls_pkg::STAT_POINT_LSB +: 16] = 16'(pts_done);
            end
            default: next_readdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         src_sel <= tls_pkg::RST_SRC_SEL;
         det_en <= tls_pkg::RST_DETECT;
         in_line <= tls_pkg::RST_IN_LINE;
         out_line <= tls_pkg::RST_OUT_LINE;
         arm_out_en <= tls_pkg::RST_ARM_OUT;
         trig_out_en <= tls_pkg::RST_TRIG_OUT;
         delay_val <= DLY_W'(tls_pkg::RST_DELAY);
         points <= PTS_W'(tls_pkg::RST_POINTS);
         pulse_len <= tls_pkg::RST_PULSE;
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0;
      end else begin
         src_sel <= next_src_sel;
         det_en <= next_det_en;
         in_line <= next_in_line;
         out_line <= next_out_line;
         arm_out_en <= next_arm_out_en;
         trig_out_en <= next_trig_out_en;
         delay_val <= next_delay_val;
         points <= next_points;
         pulse_len <= next_pulse_len;
         avs_waitrequest <= next_waitrequest;
         avs_readdata <= next_readdata;
      end
   end

   // Sequencer. Emitting states hold while a previous output pulse is still on the line.
   always_comb begin
      next_state = state;
      next_dly_count = dly_count;
      next_pts_done = pts_done;
      next_fire = 1'b0;
      case (state)
         tls_pkg::S_IDLE: begin
            if (start_req) begin
               next_state = tls_pkg::S_ENTER;
               next_pts_done = '0;
            end
         end
         tls_pkg::S_ENTER: begin
            if (!arm_out_en[0]) begin
               next_state = tls_pkg::S_WSRC;
            end else if (!out_busy) begin
               next_fire = 1'b1;
               next_state = tls_pkg::S_WSRC;
            end
         end
         tls_pkg::S_WSRC: begin
            if (detector_pass(src_sel, det_en[0], trig_seen)) begin
               next_state = tls_pkg::S_SRC;
            end
         end
         tls_pkg::S_SRC: begin
            if (src_done) begin
               next_state = tls_pkg::S_SOUT;
            end
         end
         tls_pkg::S_SOUT: begin
            if (!trig_out_en[0]) begin
               next_state = tls_pkg::S_WDLY;
            end else if (!out_busy) begin
               next_fire = 1'b1;
               next_state = tls_pkg::S_WDLY;
            end
         end
         tls_pkg::S_WDLY: begin
            if (detector_pass(src_sel, det_en[1], trig_seen)) begin
               next_dly_count = delay_val;
               next_state = tls_pkg::S_DLY;
            end
         end
         tls_pkg::S_DLY: begin
            if (dly_count == '0) begin
               next_state = tls_pkg::S_DOUT;
            end else begin
               next_dly_count = dly_count - DLY_W'(1);
            end
         end
         tls_pkg::S_DOUT: begin
            if (!trig_out_en[1]) begin
               next_state = tls_pkg::S_WMEAS;
            end else if (!out_busy) begin
               next_fire = 1'b1;
               next_state = tls_pkg::S_WMEAS;
            end
         end
         tls_pkg::S_WMEAS: begin
            if (detector_pass(src_sel, det_en[2], trig_seen)) begin
               next_state = tls_pkg::S_MEAS;
            end
         end
         tls_pkg::S_MEAS: begin
            if (meas_done) begin
               next_state = tls_pkg::S_MOUT;
            end
         end
         tls_pkg::S_MOUT: begin
            if (!trig_out_en[2] || !out_busy) begin
               next_fire = trig_out_en[2];
               next_pts_done = pts_done + PTS_W'(1);
               next_state = last_point ? tls_pkg::S_EXIT : tls_pkg::S_WSRC;
            end
         end
         tls_pkg::S_EXIT: begin
            if (!arm_out_en[1]) begin
               next_state = tls_pkg::S_IDLE;
            end else if (!out_busy) begin
               next_fire = 1'b1;
               next_state = tls_pkg::S_IDLE;
            end
         end
         default: begin
            next_state = tls_pkg::S_IDLE;
         end
      endcase
      if (abort_req) begin
         next_state = tls_pkg::S_IDLE;
         next_fire = 1'b0;
      end
      next_src_apply = (next_state == tls_pkg::S_SRC) && (state != tls_pkg::S_SRC);
      next_meas_start = (next_state == tls_pkg::S_MEAS) && (state != tls_pkg::S_MEAS);
      next_seq_busy = (next_state != tls_pkg::S_IDLE);
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state <= tls_pkg::S_IDLE;
         dly_count <= '0;
         pts_done <= '0;
         fire <= 1'b0;
         src_apply <= 1'b0;
         meas_start <= 1'b0;
         seq_busy <= 1'b0;
      end else begin
         state <= next_state;
         dly_count <= next_dly_count;
         pts_done <= next_pts_done;
         fire <= next_fire;
         src_apply <= next_src_apply;
         meas_start <= next_meas_start;
         seq_busy <= next_seq_busy;
      end
   end

endmodule // tls_top

// ===== tb/tls_top_monitor.sv
`timescale 1ns/1ps
module tls_top_monitor #(
   parameter int LINES = 4
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic [LINES-1:0] trig_line_in,
   input wire logic [LINES-1:0] trig_line_out,
   input wire logic [LINES-1:0] trig_line_oe_n,
   input wire logic src_apply,
   input wire logic src_done,
   input wire logic meas_start,
   input wire logic meas_done,
   input wire logic seq_busy
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus answer missing");
   bus_single_a: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("bus answer too long");
   bus_cause_a: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
      else $error("bus answer without request");
   line_drive_a: assert property (trig_line_out == '0)
      else $error("line driven high");
   one_line_a: assert property ($onehot0(~trig_line_oe_n))
      else $error("several lines pulled");
   line_steady_a: assert property (!(&trig_line_oe_n) && !(&$past(trig_line_oe_n))
      |-> trig_line_oe_n == $past(trig_line_oe_n))
      else $error("pulse moved line");
   idle_quiet_a: assert property (!seq_busy |-> !src_apply && !meas_start)
      else $error("action while idle");
   apply_pulse_a: assert property (src_apply |=> !src_apply)
      else $error("source start too long");
   meas_pulse_a: assert property (meas_start |=> !meas_start)
      else $error("measure start too long");
endmodule // tls_top_monitor

bind tls_top tls_top_monitor #(.LINES(LINES)) i_mon (.mclk(mclk), .rst_n(rst_n),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .trig_line_in(trig_line_in),
   .trig_line_out(trig_line_out), .trig_line_oe_n(trig_line_oe_n), .src_apply(src_apply),
   .src_done(src_done), .meas_start(meas_start), .meas_done(meas_done), .seq_busy(seq_busy));

// ===== tb/tls_far_model.sv
`timescale 1ns/1ps
module tls_far_model (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic fire,
   input wire logic [1:0] line,
   input wire logic [3:0] dut_oe_n,
   output logic [3:0] bus_lvl
);
   logic [3:0] pull_low;
   int hold;
   // Open-drain lines with pull-ups: a released line reads high.
   assign bus_lvl = ~(pull_low | ~dut_oe_n);
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pull_low <= 4'h0;
         hold <= 0;
      end else if (fire) begin
         pull_low <= 4'h1 << line;
         hold <= 6;
      end else if (hold > 1) begin
         hold <= hold - 1;
      end else begin
         pull_low <= 4'h0;
         hold <= 0;
      end
   end
endmodule // tls_far_model

// ===== tb/tls_top_bench.sv
`timescale 1ns/1ps
module tls_top_bench;
   logic mclk, rst_n, avs_read, avs_write, avs_waitrequest, src_apply, src_done;
   logic meas_start, meas_done, seq_busy, fire;
   logic [7:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic [3:0] trig_line_in, trig_line_out, trig_line_oe_n;
   logic [1:0] far_line;
   int err_total = 0, checks = 0, seed = 25, src_wait = 0, meas_wait = 0;
   int low_len = 0, n, i, pulse_len;
   int exp_q[$];
   logic [39:0] rst_tab [10] = '{40'h0000000000, 40'h0400000000, 40'h0800000010,
      40'h0c00000000, 40'h1000000000, 40'h1400000000, 40'h1800000001, 40'h1c00000064,
      40'h2000000000, 40'h3000000000};
   logic [23:0] list_tab [10] = '{24'h040707, 24'h040d05, 24'h040202, 24'h040002,
      24'h040800, 24'h0c0703, 24'h0c0400, 24'h100f07, 24'h100800, 24'h142a2a};

   tls_top i_dut (.mclk(mclk), .rst_n(rst_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .trig_line_in(trig_line_in), .trig_line_out(trig_line_out),
      .trig_line_oe_n(trig_line_oe_n), .src_apply(src_apply), .src_done(src_done),
      .meas_start(meas_start), .meas_done(meas_done), .seq_busy(seq_busy));
   tls_far_model i_far (.mclk(mclk), .rst_n(rst_n), .fire(fire), .line(far_line),
      .dut_oe_n(trig_line_oe_n), .bus_lvl(trig_line_in));

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic fail(input string msg);
      err_total++;
      $display("wrong value at %0t: %s", $time, msg);
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
      checks++;
      if (got !== exp) fail(msg);
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge mclk);
      avs_read <= !wr;
      avs_write <= wr;
      avs_address <= a;
      avs_writedata <= d;
      for (k = 0; k < 50; k++) begin
         @(posedge mclk);
         if (avs_waitrequest === 1'b0) break;
      end
      if (k == 50) begin
         fail("bus hang");
         tally_and_finish();
      end else begin
         rd = avs_readdata;
         avs_read <= 1'b0;
         avs_write <= 1'b0;
      end
   endtask
   task automatic wait_sig(input int which, input int lim);
      for (n = 1; n <= lim; n++) begin
         @(negedge mclk);
         if (which == 0 && src_apply === 1'b1) return;
         if (which == 1 && meas_start === 1'b1) return;
         if (which == 2 && seq_busy === 1'b0) return;
      end
      fail("no answer in time");
      tally_and_finish();
   endtask
   task automatic quiet(input int cyc);
      repeat (cyc) begin
         @(negedge mclk);
         checks++;
         if (src_apply !== 1'b0 || meas_start !== 1'b0) fail("sequence did not stall");
      end
   endtask
   task automatic pulse_far(input logic [1:0] l);
      @(posedge mclk);
      fire <= 1'b1;
      far_line <= l;
      @(posedge mclk);
      fire <= 1'b0;
   endtask
   task automatic setup(input logic [31:0] s, det, arm, trg, dly, pts);
      bus(1'b1, tls_pkg::REG_SOURCE, s);
      bus(1'b1, tls_pkg::REG_DETECT, det);
      bus(1'b1, tls_pkg::REG_ARM_OUT, arm);
      bus(1'b1, tls_pkg::REG_TRIG_OUT, trg);
      bus(1'b1, tls_pkg::REG_DELAY, dly);
      bus(1'b1, tls_pkg::REG_POINTS, pts);
      bus(1'b1, tls_pkg::REG_CMD, 32'h1);
   endtask
   task automatic end_test(input string name);
      repeat (pulse_len + 10) @(negedge mclk);
      check(exp_q.size(), 0, "pulse missing");
      $display("test %s done", name);
   endtask

   // Source and measure steps finish after a random short time.
   always @(posedge mclk) begin
      if (src_apply === 1'b1) src_wait <= 1 + ($random(seed) & 3);
      else if (src_wait > 0) src_wait <= src_wait - 1;
      src_done <= (src_wait == 1);
      if (meas_start === 1'b1) meas_wait <= 1 + ($random(seed) & 3);
      else if (meas_wait > 0) meas_wait <= meas_wait - 1;
      meas_done <= (meas_wait == 1);
   end

   // Each output pulse takes the oldest expected line off the queue.
   always @(negedge mclk) begin
      if (rst_n === 1'b1 && trig_line_oe_n !== 4'hf) begin
         if (low_len == 0) begin
            checks++;
            if (exp_q.size() == 0) fail("unexpected pulse");
            else if (trig_line_oe_n !== ~(4'h1 << exp_q.pop_front()))
               fail("wrong line");
         end
         low_len++;
      end else if (low_len != 0) begin
         checks++;
         if (low_len != pulse_len) fail("pulse length");
         low_len = 0;
      end
   end

   initial begin
      rst_n = 1'b0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 8'h00;
      avs_writedata = 32'h0;
      fire = 1'b0;
      far_line = 2'h0;
      pulse_len = 100;
      repeat (16) @(posedge mclk);
      rst_n <= 1'b1;
      for (i = 0; i < 10; i++) begin
         bus(1'b0, rst_tab[i][39:32], 32'h0);
         check(rd, rst_tab[i][31:0], "reset value");
      end
      $display("test reset values done");
      for (i = 0; i < 10; i++) begin
         bus(1'b1, list_tab[i][23:16], {24'h0, list_tab[i][15:8]});
         bus(1'b0, list_tab[i][23:16], 32'h0);
         check(rd, {24'h0, list_tab[i][7:0]}, "list update");
      end
      $display("test list writes done");
      pulse_len = 8;
      bus(1'b1, tls_pkg::REG_PULSE, 32'h8);
      bus(1'b1, tls_pkg::REG_LINES, 32'h02);
      repeat (5) exp_q.push_back(0);
      setup(32'h0, 32'h7, 32'h3, 32'h7, 32'h5, 32'h1);
      wait_sig(0, 100);
      wait_sig(2, 2000);
      end_test("pass-through run");
      setup(32'h1, 32'h3, 32'h4, 32'h8, 32'h28, 32'h1);
      quiet(30);
      pulse_far(2'h1);
      quiet(20);
      bus(1'b0, tls_pkg::REG_STATUS, 32'h0);
      check(rd[0], 1'b1, "busy while stalled");
      pulse_far(2'h2);
      wait_sig(0, 20);
      quiet(30);
      pulse_far(2'h2);
      wait_sig(1, 100);
      checks++;
      if (n < 41 || n > 60) fail("delay not kept");
      wait_sig(2, 200);
      end_test("bus stall run");
      repeat (2) exp_q.push_back(0);
      setup(32'h1, 32'h4, 32'h0, 32'h1, 32'h0, 32'h2);
      repeat (2) begin
         wait_sig(0, 50);
         quiet(20);
         pulse_far(2'h2);
         wait_sig(1, 30);
      end
      wait_sig(2, 100);
      end_test("measure stall run");
      setup(32'h1, 32'h1, 32'h0, 32'h0, 32'h0, 32'h1);
      quiet(10);
      bus(1'b1, tls_pkg::REG_CMD, 32'h2);
      wait_sig(2, 10);
      end_test("abort");
      tally_and_finish();
   end
endmodule // tls_top_bench
